// ### core_model.sv
// processor core model: register writes, reads and instruction fetches
`timescale 1ns/1ps
`default_nettype none
module core_model (
   input wire logic clock,
   output var wdt_pkg::reg_addr_t reg_addr,
   output var wdt_pkg::byte_t reg_wdata,
   output var logic reg_write,
   output var logic reg_read,
   output var logic fetch_valid,
   output var wdt_pkg::fetch_addr_t fetch_addr
);
   import wdt_pkg::*;
   initial begin
      {reg_addr, reg_wdata, reg_write, reg_read, fetch_valid, fetch_addr} = '0;
   end
   task automatic wr(input reg_addr_t a, input byte_t d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
      reg_wdata <= ~d;
   endtask
   // read data stand in the cycle after the strobe
   task automatic rd(input reg_addr_t a);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1;
   endtask
   task automatic fetch(input fetch_addr_t a);
      @(posedge clock);
      fetch_addr <= a;
      fetch_valid <= 1'b1;
      @(posedge clock);
      fetch_valid <= 1'b0;
      fetch_addr <= ~a;
      #1;
   endtask
endmodule
`default_nettype wire

// ### tb_watchdog_and_address_trap.sv
// self-checking bench for the watchdog and fetch trap supervisor
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defs.svh"
module tb_watchdog_and_address_trap;
   import wdt_pkg::*;
   typedef struct {fetch_addr_t a; logic hit;} row_t;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic low_speed_mode_one = 1'b0;
   reg_addr_t reg_addr;
   byte_t reg_wdata;
   fetch_addr_t fetch_addr;
   logic [7:0] reg_rdata;
   logic reg_write, reg_read, fetch_valid, wdog_overflow_irq, fetch_trap_irq;
   logic reset_pin_out, reset_pin_oe, internal_reset_req, hf_osc_restart;
   int n_errors = 0;
   int samples_checked = 0;
   int k;
   row_t rows [9] = '{'{16'h0010, 1'b1}, '{16'h003F, 1'b1}, '{16'h0040, 1'b1}, '{16'h083F, 1'b1},
      '{16'h0840, 1'b0}, '{16'h0F7F, 1'b0}, '{16'h0F80, 1'b1}, '{16'h0FFF, 1'b1}, '{16'h1000, 1'b0}};
   always #50 clock = ~clock;
   // a narrow counter makes every period 2^8 cycles, so overflow is reached inside the run
   watchdog_and_address_trap #(.CNT_W(8)) dut_u (.clock, .rstn, .reg_addr, .reg_wdata, .reg_write, .reg_read,
      .reg_rdata, .fetch_valid, .fetch_addr, .low_speed_mode_one, .wdog_overflow_irq,
      .fetch_trap_irq, .reset_pin_out, .reset_pin_oe, .internal_reset_req, .hf_osc_restart);
   core_model core_u (.clock, .reg_addr, .reg_wdata, .reg_write, .reg_read, .fetch_valid,
      .fetch_addr);
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      if (n_errors == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // ****************
   // main sequence
   // ****************
   initial begin
      repeat (6) @(posedge clock);
      rstn <= 1'b1;
      core_u.rd(`REG_STATUS);
      chk(reg_rdata, 8'hDF);
      core_u.rd(`REG_CONTROL_ONE);
      chk(reg_rdata, 8'h00);
      core_u.rd(2'h3);
      chk(reg_rdata, 8'h00);
      core_u.wr(`REG_CONTROL_ONE, 8'h8F);
      for (k = 0; k < 9; k++) begin
         core_u.fetch(rows[k].a);
         chk({7'h00, fetch_trap_irq}, {7'h00, rows[k].hit});
      end
      core_u.wr(`REG_CONTROL_ONE, 8'h0F);
      core_u.fetch(16'h0100);
      chk({7'h00, fetch_trap_irq}, 8'h01);
      core_u.wr(`REG_KEY, `KEY_COMMIT_TRAP);
      core_u.fetch(16'h0100);
      chk({7'h00, fetch_trap_irq}, 8'h00);
      core_u.fetch(16'h0020);
      chk({7'h00, fetch_trap_irq}, 8'h01);
      core_u.wr(`REG_CONTROL_ONE, 8'h0E);
      core_u.wr(`REG_CONTROL_ONE, 8'h0F);
      core_u.wr(`REG_KEY, `KEY_DISABLE);
      core_u.rd(`REG_STATUS);
      chk(reg_rdata, 8'h1E);
      core_u.wr(`REG_KEY, `KEY_CLEAR);
      core_u.wr(`REG_CONTROL_ONE, 8'h06);
      core_u.wr(`REG_KEY, `KEY_DISABLE);
      core_u.rd(`REG_STATUS);
      chk(reg_rdata, 8'h06);
      core_u.wr(`REG_CONTROL_ONE, 8'h46);
      low_speed_mode_one <= 1'b1;
      core_u.fetch(16'h0000);
      chk({4'h0, reset_pin_out, reset_pin_oe, internal_reset_req, hf_osc_restart}, 8'h07);
      k = 0;
      while (internal_reset_req === 1'b1 && k < 40) begin
         @(posedge clock);
         #1;
         k++;
      end
      chk(8'(k), 8'h18);
      rstn <= 1'b0;
      low_speed_mode_one <= 1'b0;
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      core_u.rd(`REG_STATUS);
      chk(reg_rdata, 8'hDF);
      core_u.wr(`REG_CONTROL_ONE, 8'h0E);
      core_u.wr(`REG_KEY, `KEY_CLEAR);
      k = 0;
      while (wdog_overflow_irq !== 1'b1 && k < 300) begin
         @(posedge clock);
         #1;
         k++;
      end
      chk({7'h00, k == 256}, 8'h01);
      @(posedge clock);
      #1;
      chk({7'h00, wdog_overflow_irq}, 8'h00);
      final_report();
   end
endmodule
`default_nettype wire

// ### watchdog_and_address_trap.sv
// watchdog counter and instruction fetch trap supervisor
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defs.svh"

module watchdog_and_address_trap #(
   parameter int CNT_W = 25,
   parameter logic [4:0] RESET_CYCLES = `RESET_PULSE_CYCLES
) (
   input wire logic clock,
   input wire logic rstn,
   input wire wdt_pkg::reg_addr_t reg_addr,
   input wire wdt_pkg::byte_t reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   input wire logic fetch_valid,
   input wire wdt_pkg::fetch_addr_t fetch_addr,
   input wire logic low_speed_mode_one,
   output logic wdog_overflow_irq,
   output logic fetch_trap_irq,
   output logic reset_pin_out,
   output logic reset_pin_oe,
   output logic internal_reset_req,
   output logic hf_osc_restart
);
   import wdt_pkg::*;

   // ***************************************************
   // state
   // ***************************************************
   typedef struct packed {
      logic wdog_run_enable;
      logic running;
      logic [1:0] overflow_period_select;
      logic overflow_action_select;
      logic ram_trap_pending;
      logic ram_fetch_trap_select;
      logic trap_action_select;
      logic [CNT_W-1:0] count;
      pulse_state_t pulse_state;
      logic [4:0] pulse_count;
      logic [7:0] rdata;
      logic wdog_irq;
      logic trap_irq;
      logic rst_pin;
      logic rst_oe;
      logic rst_req;
      logic osc_restart;
      logic last_cause_trap;
   } state_t;

   state_t cur_ff;
   state_t nxt_cur;

   // ***************************************************
   // helpers
   // ***************************************************
   function automatic logic in_region(input fetch_addr_t a, input fetch_addr_t lo, input fetch_addr_t hi);
      in_region = (a >= lo) && (a <= hi);
   endfunction

   function automatic logic [CNT_W-1:0] last_count(input logic [1:0] sel);
      logic [CNT_W-1:0] one;
      one = {{(CNT_W-1){1'b0}}, 1'b1};
      unique case (sel)
         2'h0: last_count = (one << 25) - one;
         2'h1: last_count = (one << 23) - one;
         2'h2: last_count = (one << 21) - one;
         2'h3: last_count = (one << 19) - one;
      endcase
   endfunction

   // ***************************************************
   // decode
   // ***************************************************
   logic wr_ctl;
   logic wr_key;
   logic key_clear;
   logic key_disable;
   logic key_commit;
   logic overflow;
   logic trap_hit;
   logic start_reset;

   always_comb begin
      wr_ctl = reg_write && (reg_addr == `REG_CONTROL_ONE);
      wr_key = reg_write && (reg_addr == `REG_KEY);
      key_clear = wr_key && (reg_wdata == `KEY_CLEAR);
      key_disable = wr_key && (reg_wdata == `KEY_DISABLE);
      key_commit = wr_key && (reg_wdata == `KEY_COMMIT_TRAP);
      overflow = cur_ff.running && (cur_ff.count == last_count(cur_ff.overflow_period_select)); // R18
      // register and debug areas trap unconditionally, ram only when armed
      trap_hit = fetch_valid && (in_region(fetch_addr, `SFR_LO, `SFR_HI) // R12
         || in_region(fetch_addr, `DBR_LO, `DBR_HI)
         || (cur_ff.ram_fetch_trap_select && in_region(fetch_addr, `RAM_LO, `RAM_HI))); // R13 R22
      start_reset = (overflow && cur_ff.overflow_action_select)
         || (trap_hit && cur_ff.trap_action_select);
   end

   // ***************************************************
   // next state
   // ***************************************************
   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.wdog_irq = 1'b0;
      nxt_cur.trap_irq = 1'b0;

      // control register one
      if (wr_ctl) begin
         nxt_cur.wdog_run_enable = reg_wdata[`BIT_RUN_ENABLE];
         nxt_cur.overflow_period_select = reg_wdata[`BIT_PERIOD_HI:`BIT_PERIOD_LO];
         // once cleared the action select stays cleared
         nxt_cur.overflow_action_select = cur_ff.overflow_action_select & reg_wdata[`BIT_OVF_ACTION]; // R19
         nxt_cur.ram_trap_pending = reg_wdata[`BIT_RAM_TRAP];
         nxt_cur.trap_action_select = reg_wdata[`BIT_TRAP_ACTION];
         if (reg_wdata[`BIT_RUN_ENABLE]) begin
            nxt_cur.running = 1'b1;
         end
      end

      // key register
      if (key_commit) begin
         nxt_cur.ram_fetch_trap_select = cur_ff.ram_trap_pending; // R10 R11
      end
      if (key_disable && !cur_ff.wdog_run_enable) begin
         nxt_cur.running = 1'b0; // R20 R02
      end

      // counter
      if (!cur_ff.running || key_clear || overflow) begin
         nxt_cur.count = '0; // R03 R21
      end else begin
         nxt_cur.count = cur_ff.count + {{(CNT_W-1){1'b0}}, 1'b1};
      end

      // non-maskable requests, one pulse per event, gated only by the action select bits
      if (overflow && !cur_ff.overflow_action_select) begin
         nxt_cur.wdog_irq = 1'b1; // R04 R05 R06
      end
      if (trap_hit && !cur_ff.trap_action_select) begin
         nxt_cur.trap_irq = 1'b1; // R13 R14 R15
      end

      // reset pulse
      unique case (cur_ff.pulse_state)
         PULSE_IDLE: begin
            if (start_reset) begin
               nxt_cur.pulse_state = PULSE_HOLD; // R08 R16
               nxt_cur.pulse_count = RESET_CYCLES - 5'h1;
               nxt_cur.rst_pin = 1'b0;
               nxt_cur.rst_oe = 1'b1;
               nxt_cur.rst_req = 1'b1;
               nxt_cur.last_cause_trap = trap_hit && cur_ff.trap_action_select;
               nxt_cur.osc_restart = trap_hit && cur_ff.trap_action_select && low_speed_mode_one; // R17
            end
         end
         PULSE_HOLD: begin
            if (cur_ff.pulse_count == 5'h0) begin
               nxt_cur.pulse_state = PULSE_IDLE; // R09
               nxt_cur.rst_oe = 1'b0;
               nxt_cur.rst_req = 1'b0;
               nxt_cur.osc_restart = 1'b0;
            end else begin
               nxt_cur.pulse_count = cur_ff.pulse_count - 5'h1;
            end
         end
      endcase

      // read data, valid the cycle after the strobe
      nxt_cur.rdata = 8'h00;
      if (reg_read && (reg_addr == `REG_STATUS)) begin
         nxt_cur.rdata = {cur_ff.ram_fetch_trap_select, cur_ff.trap_action_select,
            cur_ff.last_cause_trap, cur_ff.running, cur_ff.wdog_run_enable,
            cur_ff.overflow_period_select, cur_ff.overflow_action_select};
      end
   end

   // ***************************************************
   // registers
   // ***************************************************
   always_ff @(posedge clock) begin
      if (!rstn) begin
         cur_ff <= '0;
         cur_ff.wdog_run_enable <= 1'b1; // R01
         cur_ff.running <= 1'b1; // R01
         cur_ff.overflow_period_select <= `RST_PERIOD_SELECT;
         cur_ff.overflow_action_select <= `RST_OVF_ACTION;
         cur_ff.ram_trap_pending <= `RST_RAM_TRAP;
         cur_ff.ram_fetch_trap_select <= `RST_RAM_TRAP;
         cur_ff.trap_action_select <= `RST_TRAP_ACTION;
         cur_ff.pulse_state <= PULSE_IDLE;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   // ***************************************************
   // outputs
   // ***************************************************
   always_comb begin
      reg_rdata = cur_ff.rdata;
      wdog_overflow_irq = cur_ff.wdog_irq;
      fetch_trap_irq = cur_ff.trap_irq;
      reset_pin_out = cur_ff.rst_pin;
      reset_pin_oe = cur_ff.rst_oe;
      internal_reset_req = cur_ff.rst_req;
      hf_osc_restart = cur_ff.osc_restart;
   end
endmodule
`default_nettype wire

// ### wdt_defs.svh
// constants for the watchdog and fetch-trap supervisor
//
// How it works
// R01: watchdog enable bit resets to one, so counting starts at reset release.
// R02: software stops it: clear interrupt flag, write 4EH, clear enable, write B1H.
// R03: while the watchdog is stopped its counter is held at zero.
// R04: overflow with action select at zero raises the watchdog interrupt.
// R05: the watchdog interrupt is non-maskable, ignoring the global interrupt flag.
// R06: each new watchdog interrupt is a fresh request, serviced at once, nesting.
// R07: software sets the stack pointer before choosing interrupt on overflow.
// R08: overflow with action select at one pulls the reset pin and resets hardware.
// R09: reset from overflow or fetch trap lasts at most 24 fast clock periods.
// R10: a new ram trap select value takes effect only after key write D2H.
// R11: software running code from ram clears ram trap select and commits with D2H.
// R12: fetches from register or debug areas always trap, whatever ram select says.
// R13: trapped fetch with trap action zero raises the fetch trap interrupt.
// R14: the fetch trap interrupt is non-maskable, ignoring the global interrupt flag.
// R15: each new fetch trap interrupt is serviced at once, earlier ones held pending.
// R16: trapped fetch with trap action one pulls the reset pin and resets hardware.
// R17: fetch trap reset in low speed mode restarts the fast oscillator.
// R18: period select 00..11 gives 2^25, 2^23, 2^21, 2^19 fast clocks.
// R19: once action select is cleared, writes cannot set it again.
// R20: the disable code acts only while the enable bit is already zero.
// R21: key write 4EH clears the counter; software repeats within 3/4 period.
// R22: each fetch address is checked and flagged before the fetched code runs.
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

`define REG_CONTROL_ONE 2'h0
`define REG_KEY 2'h1
`define REG_STATUS 2'h2

`define BIT_RAM_TRAP 7
`define BIT_TRAP_ACTION 6
`define BIT_RUN_ENABLE 3
`define BIT_PERIOD_HI 2
`define BIT_PERIOD_LO 1
`define BIT_OVF_ACTION 0

`define KEY_CLEAR 8'h4E
`define KEY_DISABLE 8'hB1
`define KEY_COMMIT_TRAP 8'hD2

`define RST_PERIOD_SELECT 2'h3
`define RST_RAM_TRAP 1'b1
`define RST_TRAP_ACTION 1'b1
`define RST_OVF_ACTION 1'b1

`define RAM_LO 16'h0040
`define RAM_HI 16'h083F
`define SFR_LO 16'h0000
`define SFR_HI 16'h003F
`define DBR_LO 16'h0F80
`define DBR_HI 16'h0FFF

`define RESET_PULSE_CYCLES 5'h18

`endif

// ### wdt_pkg.sv
// types shared by the supervisor design
`default_nettype none
package wdt_pkg;
   typedef enum logic [1:0] {
      PULSE_IDLE = 2'h0,
      PULSE_HOLD = 2'h1
   } pulse_state_t;

   typedef logic [7:0] byte_t;
   typedef logic [1:0] reg_addr_t;
   typedef logic [15:0] fetch_addr_t;
endpackage
`default_nettype wire

// ### wdt_sup_assertions.sv
// port checks for the watchdog and fetch trap supervisor
`timescale 1ns/1ps
`default_nettype none
module wdt_sup_checker (
   input wire logic clock,
   input wire logic rstn,
   input wire logic fetch_valid,
   input wire wdt_pkg::fetch_addr_t fetch_addr,
   input wire logic wdog_overflow_irq,
   input wire logic fetch_trap_irq,
   input wire logic reset_pin_out,
   input wire logic reset_pin_oe,
   input wire logic internal_reset_req,
   input wire logic hf_osc_restart
);
   import wdt_pkg::*;
   // counts the high cycles of the current reset pulse
   logic [5:0] hi_cnt_ff;
   always_ff @(posedge clock) begin
      hi_cnt_ff <= (rstn && internal_reset_req) ? hi_cnt_ff + 6'h01 : 6'h00;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   a_sfr_fetch_trap: assert property (fetch_valid && fetch_addr <= 16'h003F
      |=> fetch_trap_irq || internal_reset_req) else $error("register area fetch missed");
   a_dbr_fetch_trap: assert property (fetch_valid && fetch_addr inside {[16'h0F80:16'h0FFF]}
      |=> fetch_trap_irq || internal_reset_req) else $error("debug area fetch missed");
   a_trap_irq_cause: assert property (fetch_trap_irq |-> $past(fetch_valid))
      else $error("trap irq without fetch");
   a_wdog_irq_pulse: assert property (wdog_overflow_irq |=> !wdog_overflow_irq)
      else $error("watchdog irq too long");
   a_reset_len_max: assert property (hi_cnt_ff <= 6'h18)
      else $error("reset pulse too long");
   a_reset_len_full: assert property ($fell(internal_reset_req) |-> hi_cnt_ff == 6'h18)
      else $error("reset pulse length wrong");
   a_pin_drives_low: assert property (reset_pin_oe == internal_reset_req && !reset_pin_out)
      else $error("reset pin mismatch");
   a_osc_in_reset: assert property (hf_osc_restart |-> internal_reset_req)
      else $error("osc restart outside reset");
endmodule
bind watchdog_and_address_trap wdt_sup_checker chk_u (.clock, .rstn, .fetch_valid, .fetch_addr,
   .wdog_overflow_irq, .fetch_trap_irq, .reset_pin_out, .reset_pin_oe, .internal_reset_req,
   .hf_osc_restart);
`default_nettype wire
